// >>> bench/lci_channel_coding_irq_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module lci_channel_coding_irq_ctrl_test;
    import lci_pkg::*;
    // clock and reset
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    // apb master side
    logic [LCI_AW-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [LCI_DW-1:0] pwdata = '0;
    logic [LCI_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    // line side stimulus and outputs
    logic [LCI_NCH-1:0] tx_line_clock = '0;
    logic [LCI_NCH-1:0][7:0] alarm_flags = '0;
    lci_chan_cfg_t chan_cfg;
    lci_inj_t inject;
    logic irq;
    // bookkeeping and last read answer
    int miscompares = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic er;

    // 250 MHz clock
    always #2 clk = ~clk;

    lci_channel_coding_irq_ctrl dut (
        .clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_line_clock(tx_line_clock), .alarm_flags(alarm_flags), .chan_cfg(chan_cfg),
        .inject(inject), .irq(irq)
    );

    // single place where the run ends
    task close_out;
        $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // case-equality compare so an unknown never matches
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; pready and the answer are taken at the rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // values read right after the edge are the ones the edge sampled
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        // request held through the edge that sampled pready, released now
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // byte address of channel c, register slot s
    function automatic logic [11:0] ca(input int c, input int s);
        return 12'(c * 64 + s * 4);
    endfunction : ca

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
        chk({31'h0, er}, 32'h0000_0000);
    endtask : rdchk

    // fixed settle: istat one cycle, pin one more
    task settle;
        repeat (4) @(posedge clk);
    endtask : settle

    // every channel register comes up zero
    task t_reset;
        for (int c = 0; c < LCI_NCH; c++) begin
            rdchk(ca(c, 3), 32'h0000_0000);
            rdchk(ca(c, 4), 32'h0000_0000);
        end
        rdchk(12'h380, 32'h0000_0000);
    endtask : t_reset

    // coding cycles through four patterns across the channels, reserved bits stored, fields reach the pins
    task t_coding;
        logic [7:0] d;
        lci_chan_cfg_t exp;
        exp = '0;
        for (int c = 0; c < LCI_NCH; c++) begin
            d = 8'hC1 | 8'((c % 2) << 5) | 8'((c % 4) << 3);
            exp.line_code_select[c] = 1'(c % 2);
            exp.rx_resistor_select[c] = 2'(c % 4);
            wr(ca(c, 3), {24'h0, d});
            rdchk(ca(c, 3), {24'h0, d});
        end
        chk(32'(chan_cfg.line_code_select), 32'(exp.line_code_select));
        chk(32'(chan_cfg.rx_resistor_select), 32'(exp.rx_resistor_select));
        wr(ca(7, 4), 32'h0000_0088);
        rdchk(ca(7, 4), 32'h0000_0088);
        wr(ca(7, 4), 32'h0000_0000);
    endtask : t_coding

    // unmapped address answers with an error and no data
    task t_refuse;
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        wr(12'h000, 32'h0000_00FF);
        rdchk(ca(0, 3), 32'h0000_00C1);
    endtask : t_refuse

    // write coding, then one line clock pulse; count insertion cycles
    task inj_run(input int c, input logic [7:0] d, input int eb, input int ee);
        int nb;
        int ne;
        wr(ca(c, 3), {24'h0, d});
        nb = 0;
        ne = 0;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            tx_line_clock[c] <= (i >= 4 && i < 12);
            @(negedge clk);
            if (inject.bpv[c] === 1'b1) nb++;
            if (inject.ber[c] === 1'b1) ne++;
        end
        chk(nb, eb);
        chk(ne, ee);
    endtask : inj_run

    task t_inject;
        inj_run(3, 8'h04, 1, 0);
        inj_run(3, 8'h04, 0, 0);
        inj_run(3, 8'h00, 0, 0);
        inj_run(3, 8'h02, 0, 1);
        inj_run(3, 8'h06, 1, 0);
        inj_run(13, 8'h00, 0, 0);
        inj_run(13, 8'h06, 1, 1);
    endtask : t_inject

    // each source bit raises the pin only with its own enable and the global one
    task t_irq;
        int bits[6] = '{6, 5, 4, 2, 1, 0};
        wr(12'h38C, 32'h0000_3FFF);
        wr(12'h380, 32'h0000_0001);
        foreach (bits[i]) begin
            wr(ca(5, 4), 32'(1 << bits[i]));
            alarm_flags[5] <= 8'(1 << bits[i]);
            settle();
            chk({31'h0, irq}, 32'h0000_0001);
            rdchk(12'h384, 32'h0000_0020);
            alarm_flags[5] <= 8'h00;
            wr(12'h388, 32'h0000_0020);
            settle();
            chk({31'h0, irq}, 32'h0000_0000);
        end
        // masked source: flag still visible, no status, no pin
        wr(ca(5, 4), 32'h0000_0088);
        alarm_flags[5] <= 8'h77;
        settle();
        chk({31'h0, irq}, 32'h0000_0000);
        rdchk(ca(5, 5), 32'h0000_0077);
        rdchk(12'h384, 32'h0000_0000);
        alarm_flags[5] <= 8'h00;
        // last channel merges into the pin, global enable gates it
        wr(ca(13, 4), 32'h0000_0001);
        alarm_flags[13] <= 8'h01;
        settle();
        chk({31'h0, irq}, 32'h0000_0001);
        wr(12'h380, 32'h0000_0000);
        settle();
        chk({31'h0, irq}, 32'h0000_0000);
        rdchk(12'h384, 32'h0000_2000);
    endtask : t_irq

    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_coding();
        t_refuse();
        t_inject();
        t_irq();
        close_out();
    end
endmodule : lci_channel_coding_irq_ctrl_test
`default_nettype wire

// >>> hdl/lci_channel_coding_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - code bit picks zero-substitution or AMI
// - two bits select receive resistor value
// - violation bit rise inserts one violation
// - insertions wait for next line clock rise
// - error bit rise inserts one bit error
// - enables for driver, fifo, code violation
// - enables for all-ones, signal loss, pattern
// - pin needs channel and global enable
// - reserved bits store, reset zero, inert
// - fourteen channel copies, sixteen-word stride
// - flags track regardless of mask
module lci_channel_coding_irq_ctrl
    import lci_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic [LCI_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [LCI_DW-1:0] pwdata,
    output logic [LCI_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // line side
    input wire logic [LCI_NCH-1:0] tx_line_clock,
    input wire logic [LCI_NCH-1:0][7:0] alarm_flags,
    // channel controls
    output lci_chan_cfg_t chan_cfg,
    output lci_inj_t inject,
    // interrupt
    output logic irq
);

    // address to register, channel slots then globals
    function automatic lci_dec_t lci_decode(input logic [LCI_AW-1:0] addr);
        lci_dec_t d;
        logic [7:0] idx;
        idx = addr[LCI_IDX_MSB:LCI_IDX_LSB];
        d.sel = LCI_SEL_NONE;
        d.ch = idx[7:LCI_SUB_W];
        // upper bits and byte offset must be zero
        if (addr[LCI_IDX_LSB-1:0] == '0 && addr[LCI_AW-1:LCI_IDX_MSB+1] == '0) begin
            if (idx == LCI_IDX_GLOBAL) begin
                d.sel = LCI_SEL_GLOBAL;
            end else if (idx == LCI_IDX_ISTAT) begin
                d.sel = LCI_SEL_ISTAT;
            end else if (idx == LCI_IDX_ICLR) begin
                d.sel = LCI_SEL_ICLR;
            end else if (idx == LCI_IDX_IEN) begin
                d.sel = LCI_SEL_IEN;
            end else if (d.ch < LCI_NCH) begin
                if (idx[LCI_SUB_W-1:0] == LCI_SUB_CODE) begin
                    d.sel = LCI_SEL_CODE;
                end else if (idx[LCI_SUB_W-1:0] == LCI_SUB_IE) begin
                    d.sel = LCI_SEL_IE;
                end else if (idx[LCI_SUB_W-1:0] == LCI_SUB_FLAG) begin
                    d.sel = LCI_SEL_FLAG;
                end
            end
        end
        return d;
    endfunction : lci_decode

    // all state of the module
    typedef struct packed {
        logic [LCI_NCH-1:0][7:0] code;
        logic [LCI_NCH-1:0][7:0] ie;
        logic [7:0] glob;
        logic [LCI_DW-1:0] rdata;
        logic rdy;
        logic err;
        lci_inj_t req;
    } lci_main_st_t;

    lci_main_st_t st_q;
    lci_main_st_t st_d;

    // decoded access
    lci_dec_t dec;
    // setup phase of an apb transfer
    logic setup_ph;
    // write takes effect this edge
    logic wr_en;
    // low byte of the write data
    logic [7:0] wbyte;
    // read value chosen at setup
    logic [LCI_DW-1:0] rd_val;
    // per channel enabled source active
    logic [LCI_NCH-1:0] chan_hit;
    // interrupt block read back
    logic [LCI_NCH-1:0] istat;
    logic [LCI_NCH-1:0] ien;
    // global enable level
    logic global_irq_enable;

    // bus phase decode
    always_comb begin
        dec = lci_decode(paddr);
        setup_ph = psel && !penable;
        // ready is only high in the access cycle, so one write per transfer
        wr_en = psel && penable && st_q.rdy && pwrite;
        wbyte = pwdata[7:0];
        global_irq_enable = st_q.glob[LCI_BIT_GIE];
    end

    // read mux, registered at setup so prdata comes from a flop
    always_comb begin
        rd_val = '0;
        unique case (dec.sel)
            LCI_SEL_CODE: begin
                rd_val = LCI_DW'(st_q.code[dec.ch]);
            end
            LCI_SEL_IE: begin
                rd_val = LCI_DW'(st_q.ie[dec.ch]);
            end
            LCI_SEL_FLAG: begin
                rd_val = LCI_DW'(alarm_flags[dec.ch] & LCI_IE_USED);
            end
            LCI_SEL_GLOBAL: begin
                rd_val = LCI_DW'(st_q.glob);
            end
            LCI_SEL_ISTAT: begin
                rd_val = LCI_DW'(istat);
            end
            LCI_SEL_IEN: begin
                rd_val = LCI_DW'(ien);
            end
            LCI_SEL_NONE, LCI_SEL_ICLR: begin
                // clear register is write-only
                rd_val = '0;
            end
        endcase
    end

    // per channel source gating
    always_comb begin
        for (int i = 0; i < LCI_NCH; i++) begin
            chan_hit[i] = (alarm_flags[i] & st_q.ie[i] & LCI_IE_USED) != '0;
        end
    end

    // next state
    always_comb begin
        st_d = st_q;
        // requests are single-cycle
        st_d.req = '0;
        // zero wait state: answer in the cycle after setup
        st_d.rdy = setup_ph;
        st_d.err = setup_ph && (dec.sel == LCI_SEL_NONE);
        if (setup_ph) begin
            st_d.rdata = rd_val;
        end
        if (wr_en) begin
            unique case (dec.sel)
                LCI_SEL_CODE: begin
                    st_d.code[dec.ch] = wbyte;
                    st_d.req.bpv[dec.ch] = wbyte[LCI_BIT_BPV] && !st_q.code[dec.ch][LCI_BIT_BPV];
                    st_d.req.ber[dec.ch] = wbyte[LCI_BIT_BER] && !st_q.code[dec.ch][LCI_BIT_BER];
                end
                LCI_SEL_IE: begin
                    st_d.ie[dec.ch] = wbyte;
                end
                LCI_SEL_GLOBAL: begin
                    st_d.glob = wbyte;
                end
                LCI_SEL_NONE, LCI_SEL_FLAG, LCI_SEL_ISTAT, LCI_SEL_ICLR, LCI_SEL_IEN: begin
                    // read-only or handled by the interrupt block
                end
            endcase
        end
    end

    // state register, everything clears to zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // line settings straight from stored bits
    always_comb begin
        for (int i = 0; i < LCI_NCH; i++) begin
            chan_cfg.line_code_select[i] = st_q.code[i][LCI_BIT_CODE];
            chan_cfg.rx_resistor_select[i] = st_q.code[i][LCI_RES_HI:LCI_RES_LO];
        end
    end

    assign prdata = st_q.rdata;
    assign pready = st_q.rdy;
    assign pslverr = st_q.err;

    // transmit-side insertion timing
    lci_inject_edge u_inject (
        .clk(clk),
        .sys_rst(sys_rst),
        .req(st_q.req),
        .tx_line_clock(tx_line_clock),
        .pulse(inject)
    );

    // interrupt status and pin
    lci_irq_agg u_irq (
        .clk(clk),
        .sys_rst(sys_rst),
        .chan_hit(chan_hit),
        .global_irq_enable(global_irq_enable),
        .clr_we(wr_en && dec.sel == LCI_SEL_ICLR),
        .ien_we(wr_en && dec.sel == LCI_SEL_IEN),
        .wdata(pwdata[LCI_NCH-1:0]),
        .istat(istat),
        .ien(ien),
        .irq(irq)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single access cycle");

    chk_unmapped_err: assert property (psel && !penable && dec.sel == LCI_SEL_NONE |=> pslverr && prdata == '0)
        else $error("unmapped access not flagged");

    chk_ch_range: assert property (psel && dec.sel == LCI_SEL_CODE |-> dec.ch < LCI_NCH)
        else $error("coding access outside channel range");

    chk_code_store: assert property (wr_en && dec.sel == LCI_SEL_CODE |=> st_q.code[$past(dec.ch)] == $past(wbyte))
        else $error("coding write not stored");

    chk_glob_store: assert property (wr_en && dec.sel == LCI_SEL_GLOBAL |=> st_q.glob == $past(wbyte))
        else $error("global write not stored");

    chk_code_pin: assert property (wr_en && dec.sel == LCI_SEL_CODE |=> chan_cfg.line_code_select[$past(dec.ch)] == $past(wbyte[LCI_BIT_CODE]))
        else $error("line code select not applied");

    chk_res_pin: assert property (wr_en && dec.sel == LCI_SEL_CODE |=> chan_cfg.rx_resistor_select[$past(dec.ch)] == $past(wbyte[LCI_RES_HI:LCI_RES_LO]))
        else $error("resistor select not applied");

    chk_bpv_rise: assert property (wr_en && dec.sel == LCI_SEL_CODE && wbyte[LCI_BIT_BPV] && !st_q.code[dec.ch][LCI_BIT_BPV] |=> st_q.req.bpv != '0)
        else $error("violation request missing");

    chk_ber_rise: assert property (wr_en && dec.sel == LCI_SEL_CODE && wbyte[LCI_BIT_BER] && !st_q.code[dec.ch][LCI_BIT_BER] |=> st_q.req.ber != '0)
        else $error("error request missing");

    chk_no_rise: assert property (wr_en && dec.sel == LCI_SEL_CODE && st_q.code[dec.ch][LCI_BIT_BER] |=> st_q.req.ber == '0)
        else $error("error request without rise");

    chk_no_rise_bpv: assert property (wr_en && dec.sel == LCI_SEL_CODE && st_q.code[dec.ch][LCI_BIT_BPV] |=> st_q.req.bpv == '0)
        else $error("violation request without rise");

    chk_req_cause: assert property ((st_q.req.bpv | st_q.req.ber) != '0 |-> $past(wr_en))
        else $error("request without a write");

    chk_req_single: assert property ((st_q.req.bpv | st_q.req.ber) != '0 |=> (st_q.req.bpv | st_q.req.ber) == '0)
        else $error("insertion request held too long");

    chk_ie_store: assert property (wr_en && dec.sel == LCI_SEL_IE |=> st_q.ie[$past(dec.ch)] == $past(wbyte))
        else $error("enable write not stored");

    chk_hit_sets: assert property (chan_hit != '0 |=> (istat & $past(chan_hit)) == $past(chan_hit))
        else $error("enabled source did not set status");

    chk_flag_read: assert property (psel && !penable && dec.sel == LCI_SEL_FLAG |=> prdata == $past(LCI_DW'(alarm_flags[dec.ch] & LCI_IE_USED)))
        else $error("flag read does not show live flags");

    chk_irq_needs_gie: assert property (irq |-> $past(global_irq_enable))
        else $error("pin high without global enable");

    chk_irq_any: assert property (global_irq_enable && (istat & ien) != '0 |=> irq)
        else $error("pin not raised for enabled status");

endmodule : lci_channel_coding_irq_ctrl
`default_nettype wire

// >>> hdl/lci_inject_edge.sv
`timescale 1ns/1ps
`default_nettype none
module lci_inject_edge
    import lci_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // requests from the register side
    input wire lci_inj_t req,
    // per channel transmit line clocks
    input wire logic [LCI_NCH-1:0] tx_line_clock,
    // one-cycle insertion pulses
    output lci_inj_t pulse
);

    // all state of the module
    typedef struct packed {
        lci_inj_t pend;
        logic [LCI_NCH-1:0] tx_line_clock_prev;
        lci_inj_t out;
    } lci_inj_st_t;

    lci_inj_st_t st_q;
    lci_inj_st_t st_d;
    logic [LCI_NCH-1:0] tx_line_clock_rise;

    // requests wait for the next line clock rise
    always_comb begin
        st_d = st_q;
        tx_line_clock_rise = tx_line_clock & ~st_q.tx_line_clock_prev;
        st_d.tx_line_clock_prev = tx_line_clock;
        st_d.out.bpv = tx_line_clock_rise & st_q.pend.bpv;
        st_d.out.ber = tx_line_clock_rise & st_q.pend.ber;
        // one pulse per request, set wins
        st_d.pend.bpv = req.bpv | (st_q.pend.bpv & ~tx_line_clock_rise);
        st_d.pend.ber = req.ber | (st_q.pend.ber & ~tx_line_clock_rise);
    end

    // state register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pulse = st_q.out;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_pulse_single: assert property ((pulse.bpv | pulse.ber) != '0 |=> (pulse.bpv & $past(pulse.bpv)) == '0)
        else $error("insertion pulse lasted two cycles");
    chk_pend_kept: assert property ((st_q.pend.bpv & ~tx_line_clock_rise) != '0 |=> (st_q.pend.bpv & $past(st_q.pend.bpv & ~tx_line_clock_rise)) == $past(st_q.pend.bpv & ~tx_line_clock_rise))
        else $error("pending violation lost before line rise");

endmodule : lci_inject_edge
`default_nettype wire

// >>> hdl/lci_irq_agg.sv
`timescale 1ns/1ps
`default_nettype none
module lci_irq_agg
    import lci_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // per channel enabled source active
    input wire logic [LCI_NCH-1:0] chan_hit,
    input wire logic global_irq_enable,
    // software access
    input wire logic clr_we,
    input wire logic ien_we,
    input wire logic [LCI_NCH-1:0] wdata,
    output logic [LCI_NCH-1:0] istat,
    output logic [LCI_NCH-1:0] ien,
    // interrupt level
    output logic irq
);

    // all state of the module
    typedef struct packed {
        logic [LCI_NCH-1:0] stat;
        logic [LCI_NCH-1:0] en;
        logic irq;
    } lci_irq_st_t;

    lci_irq_st_t st_q;
    lci_irq_st_t st_d;

    // sticky status, set beats clear
    always_comb begin
        st_d = st_q;
        st_d.stat = (st_q.stat & ~(clr_we ? wdata : '0)) | chan_hit;
        if (ien_we) begin
            st_d.en = wdata;
        end
        st_d.irq = global_irq_enable && ((st_q.stat & st_q.en) != '0);
    end

    // state register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign istat = st_q.stat;
    assign ien = st_q.en;
    assign irq = st_q.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_irq_gie: assert property (!global_irq_enable |=> !irq)
        else $error("interrupt raised without global enable");
    chk_set_wins: assert property (chan_hit != '0 |=> (istat & $past(chan_hit)) == $past(chan_hit))
        else $error("status event lost");

endmodule : lci_irq_agg
`default_nettype wire

// >>> hdl/lci_pkg.sv
`default_nettype none
// shared constants and carriers for the channel coding and interrupt block
package lci_pkg;

    // sizes
    localparam int LCI_NCH = 14;
    localparam int LCI_AW = 12;
    localparam int LCI_DW = 32;
    localparam int LCI_SUB_W = 4;

    // word index taken from byte address bits
    localparam int LCI_IDX_LSB = 2;
    localparam int LCI_IDX_MSB = 9;

    // per channel register index inside a 16-word channel slot
    localparam logic [3:0] LCI_SUB_CODE = 4'h3;
    localparam logic [3:0] LCI_SUB_IE = 4'h4;
    localparam logic [3:0] LCI_SUB_FLAG = 4'h5;

    // global register indices
    localparam logic [7:0] LCI_IDX_GLOBAL = 8'hE0;
    localparam logic [7:0] LCI_IDX_ISTAT = 8'hE1;
    localparam logic [7:0] LCI_IDX_ICLR = 8'hE2;
    localparam logic [7:0] LCI_IDX_IEN = 8'hE3;

    // field positions of the coding register
    localparam int LCI_BIT_CODE = 5;
    localparam int LCI_RES_HI = 4;
    localparam int LCI_RES_LO = 3;
    localparam int LCI_BIT_BPV = 2;
    localparam int LCI_BIT_BER = 1;

    // field position of the global enable
    localparam int LCI_BIT_GIE = 0;

    // used bits of the enable and flag layout
    localparam logic [7:0] LCI_IE_USED = 8'h77;
    localparam logic [7:0] LCI_REG_RST = 8'h00;

    // register selected by an address
    typedef enum logic [2:0] {
        LCI_SEL_NONE, LCI_SEL_CODE, LCI_SEL_IE, LCI_SEL_FLAG,
        LCI_SEL_GLOBAL, LCI_SEL_ISTAT, LCI_SEL_ICLR, LCI_SEL_IEN
    } lci_sel_t;

    // decoded address
    typedef struct packed {
        lci_sel_t sel;
        logic [3:0] ch;
    } lci_dec_t;

    // static line settings per channel
    typedef struct packed {
        logic [LCI_NCH-1:0] line_code_select;
        logic [LCI_NCH-1:0][1:0] rx_resistor_select;
    } lci_chan_cfg_t;

    // insertion requests or pulses per channel
    typedef struct packed {
        logic [LCI_NCH-1:0] bpv;
        logic [LCI_NCH-1:0] ber;
    } lci_inj_t;

endpackage : lci_pkg
`default_nettype wire
